// ===== rtl/uart_aux_pkg.sv
// Package of register map, field layout and types for the FIFO/DMA aux block
package uart_aux_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [31:0] ADR_TX_EMPTY_THRESHOLD_SHADOW = 32'h500010A0;
	localparam logic [31:0] ADR_TRANSMIT_HALT_CONTROL = 32'h500010A4;
	localparam logic [31:0] ADR_DMA_SOFTWARE_ACKNOWLEDGE = 32'h500010A8;
	localparam logic [31:0] ADR_FIFO_CONTROL_REGISTER = 32'h500010B0;
	localparam logic [31:0] ADR_IRQ_STATUS = 32'h500010B4;
	localparam logic [31:0] ADR_IRQ_MASK = 32'h500010B8;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FCR_ENABLE_BIT = 0;
	localparam int FCR_PROG_MODE_BIT = 3;
	localparam int FCR_THRESH_LSB = 4;
	localparam int FCR_THRESH_MSB = 5;
	localparam int SHADOW_THRESH_LSB = 0;
	localparam int SHADOW_THRESH_MSB = 1;
	localparam int HALT_BIT = 0;
	localparam int DMA_ACK_BIT = 0;
	localparam int IRQ_BITS = 3;
	localparam int IRQ_TX_EMPTY = 0;
	localparam int IRQ_DMA_ACK = 1;
	localparam int IRQ_FIFO_RESET = 2;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [1:0] THRESH_RESET = 2'h0;
	localparam logic HALT_RESET = 1'h0;
	localparam logic FIFO_ENABLE_RESET = 1'h0;
	localparam logic PROG_MODE_RESET = 1'h0;
	localparam logic [IRQ_BITS-1:0] IRQ_RESET = 3'h0;
	localparam logic [31:0] READ_ZERO = 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// Transmit-empty threshold encodings
	typedef enum logic [1:0]
	{
		THR_EMPTY = 2'h0,
		THR_TWO_CHARS = 2'h1,
		THR_QUARTER = 2'h2,
		THR_HALF = 2'h3
	} tx_thresh_t;

	localparam int TWO_CHARS = 2;

	// DMA handshake lines
	typedef struct packed
	{
		logic tx_req;
		logic tx_single;
		logic rx_req;
		logic rx_single;
	} dma_lines_t;

endpackage : uart_aux_pkg

// ===== rtl/uart_fifo_dma_aux_control.sv
// FIFO/DMA auxiliary control of a serial port with a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE_01] Shadow write changes only threshold; read returns it
// [RULE_02] Threshold codes: empty, two, quarter, half
// [RULE_03] Programmable mode: empty interrupt at/below threshold
// [RULE_04] Halt stops sending when FIFOs enabled
// [RULE_05] Halt ignored while FIFOs disabled
// [RULE_06] Soft acknowledge withdraws all four DMA lines
// [RULE_07] Soft acknowledge bit clears itself
// [RULE_08] Software acknowledges after DMA channel error
// [RULE_09] Enable bit gates both FIFOs; clearing resets
// [RULE_10] Write-only and reserved bits read zero
module uart_fifo_dma_aux_control
#(
	parameter int FIFO_DEPTH = 16,
	parameter int LEVEL_W = $clog2(FIFO_DEPTH) + 1
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [31:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic [LEVEL_W-1:0] TX_FIFO_LEVEL,
	input wire uart_aux_pkg::dma_lines_t DMA_REQ_RAW,
	output uart_aux_pkg::dma_lines_t DMA_REQ,
	output logic TX_EMPTY_INT,
	output logic TX_HALT,
	output logic FIFO_ENABLE,
	output logic FIFO_RESET,
	output logic IRQ
);

	////////////////////////////////////////////////////////////////////////
	// Threshold levels in characters
	localparam logic [LEVEL_W-1:0] LVL_EMPTY = '0;
	localparam logic [LEVEL_W-1:0] LVL_TWO =
		LEVEL_W'(uart_aux_pkg::TWO_CHARS);
	localparam logic [LEVEL_W-1:0] LVL_QUARTER = LEVEL_W'(FIFO_DEPTH / 4);
	localparam logic [LEVEL_W-1:0] LVL_HALF = LEVEL_W'(FIFO_DEPTH / 2);

	////////////////////////////////////////////////////////////////////////
	// Reset levels of the single-bit flops and the DMA lines
	localparam logic BIT_RESET = 1'h0;
	localparam uart_aux_pkg::dma_lines_t DMA_NONE = '0;

	////////////////////////////////////////////////////////////////////////
	// State
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [1:0] thresh_ff;
	logic halt_ff;
	logic fifo_en_ff;
	logic prog_mode_ff;
	logic [uart_aux_pkg::IRQ_BITS-1:0] status_ff;
	logic [uart_aux_pkg::IRQ_BITS-1:0] mask_ff;
	logic irq_ff;
	logic tx_empty_ff;
	logic tx_halt_ff;
	logic fifo_reset_ff;
	uart_aux_pkg::dma_lines_t block_ff;
	uart_aux_pkg::dma_lines_t dma_ff;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire logic bus_req;
	wire logic wr_commit;
	wire logic lane0;
	wire logic hit_shadow;
	wire logic hit_halt;
	wire logic hit_dma_ack;
	wire logic hit_fcr;
	wire logic hit_status;
	wire logic hit_mask;

	assign bus_req = CYC_I & STB_I;
	// A write takes effect at the edge where the master sees ack
	assign wr_commit = bus_req & WE_I & ack_ff;
	// Every field sits in byte lane 0
	assign lane0 = SEL_I[0];
	// Full address match; misses read zero and drop writes
	assign hit_shadow = ADR_I == uart_aux_pkg::ADR_TX_EMPTY_THRESHOLD_SHADOW;
	assign hit_halt = ADR_I == uart_aux_pkg::ADR_TRANSMIT_HALT_CONTROL;
	assign hit_dma_ack = ADR_I == uart_aux_pkg::ADR_DMA_SOFTWARE_ACKNOWLEDGE;
	assign hit_fcr = ADR_I == uart_aux_pkg::ADR_FIFO_CONTROL_REGISTER;
	assign hit_status = ADR_I == uart_aux_pkg::ADR_IRQ_STATUS;
	assign hit_mask = ADR_I == uart_aux_pkg::ADR_IRQ_MASK;

	wire logic wr_lane0;
	wire logic wr_shadow;
	wire logic wr_halt;
	wire logic wr_fcr;
	wire logic wr_status;
	wire logic wr_mask;
	wire logic soft_ack;

	assign wr_lane0 = wr_commit & lane0;
	assign wr_shadow = wr_lane0 & hit_shadow;
	assign wr_halt = wr_lane0 & hit_halt;
	assign wr_fcr = wr_lane0 & hit_fcr;
	assign wr_status = wr_lane0 & hit_status;
	assign wr_mask = wr_lane0 & hit_mask;
	// One-cycle strobe; nothing is stored, so the bit is self-clearing
	assign soft_ack = wr_lane0 & hit_dma_ack
		& DAT_I[uart_aux_pkg::DMA_ACK_BIT]; // [RULE_06] [RULE_07]

	////////////////////////////////////////////////////////////////////////
	// Next values of the control fields
	wire logic [1:0] nxt_thresh;
	wire logic nxt_halt;
	wire logic nxt_fifo_en;
	wire logic nxt_prog_mode;
	wire logic [uart_aux_pkg::IRQ_BITS-1:0] nxt_mask;

	// Shadow write touches only the threshold field
	assign nxt_thresh = wr_shadow ?
		DAT_I[uart_aux_pkg::SHADOW_THRESH_MSB:
			uart_aux_pkg::SHADOW_THRESH_LSB] :
		wr_fcr ?
		DAT_I[uart_aux_pkg::FCR_THRESH_MSB:uart_aux_pkg::FCR_THRESH_LSB] :
		thresh_ff; // [RULE_01]
	assign nxt_halt = wr_halt ? DAT_I[uart_aux_pkg::HALT_BIT] : halt_ff;
	assign nxt_fifo_en = wr_fcr ?
		DAT_I[uart_aux_pkg::FCR_ENABLE_BIT] : fifo_en_ff; // [RULE_09]
	assign nxt_prog_mode = wr_fcr ?
		DAT_I[uart_aux_pkg::FCR_PROG_MODE_BIT] : prog_mode_ff;
	assign nxt_mask = wr_mask ?
		DAT_I[uart_aux_pkg::IRQ_BITS-1:0] : mask_ff;

	////////////////////////////////////////////////////////////////////////
	// FIFO controller reset on an enabled-to-disabled change
	wire logic nxt_fifo_reset;

	// One-cycle pulse; reset itself gives none
	assign nxt_fifo_reset = fifo_en_ff & ~nxt_fifo_en; // [RULE_09]

	////////////////////////////////////////////////////////////////////////
	// Transmitter-empty threshold decode
	logic [LEVEL_W-1:0] thresh_level;

	// Quarter and half levels follow the FIFO depth
	always_comb
	begin
		case (uart_aux_pkg::tx_thresh_t'(thresh_ff)) // [RULE_02]
			uart_aux_pkg::THR_EMPTY: thresh_level = LVL_EMPTY;
			uart_aux_pkg::THR_TWO_CHARS: thresh_level = LVL_TWO;
			uart_aux_pkg::THR_QUARTER: thresh_level = LVL_QUARTER;
			uart_aux_pkg::THR_HALF: thresh_level = LVL_HALF;
			default: thresh_level = LVL_EMPTY;
		endcase
	end

	wire logic prog_active;
	wire logic nxt_tx_empty;

	// Programmable mode needs the FIFOs enabled; else plain empty test
	assign prog_active = prog_mode_ff & fifo_en_ff;
	// At or below the threshold counts as empty
	assign nxt_tx_empty = prog_active ?
		(TX_FIFO_LEVEL <= thresh_level) :
		(TX_FIFO_LEVEL == LVL_EMPTY); // [RULE_03]

	////////////////////////////////////////////////////////////////////////
	// Transmit halt
	wire logic nxt_tx_halt;

	// Halt only counts while the FIFOs are enabled
	// Writes into the transmit FIFO still land while halted
	assign nxt_tx_halt = halt_ff & fifo_en_ff; // [RULE_04] [RULE_05]

	////////////////////////////////////////////////////////////////////////
	// DMA request withdrawal
	uart_aux_pkg::dma_lines_t nxt_block;
	uart_aux_pkg::dma_lines_t nxt_dma;

	// A line stays withdrawn until its source drops; acknowledge wins
	// Lines already low at the acknowledge stay free to rise again
	assign nxt_block = soft_ack ? DMA_REQ_RAW :
		(block_ff & DMA_REQ_RAW); // [RULE_06] [RULE_08]
	assign nxt_dma = DMA_REQ_RAW & ~nxt_block; // [RULE_06]

	////////////////////////////////////////////////////////////////////////
	// Interrupt status
	wire logic [uart_aux_pkg::IRQ_BITS-1:0] events;
	wire logic [uart_aux_pkg::IRQ_BITS-1:0] clr_bits;
	wire logic [uart_aux_pkg::IRQ_BITS-1:0] nxt_status;
	wire logic nxt_irq;

	// Rising edge of the empty condition
	assign events[uart_aux_pkg::IRQ_TX_EMPTY] = nxt_tx_empty & ~tx_empty_ff;
	assign events[uart_aux_pkg::IRQ_DMA_ACK] = soft_ack;
	assign events[uart_aux_pkg::IRQ_FIFO_RESET] = nxt_fifo_reset;
	// Sticky status; writing a one clears a bit
	assign clr_bits = wr_status ?
		DAT_I[uart_aux_pkg::IRQ_BITS-1:0] : uart_aux_pkg::IRQ_RESET;
	// A new event wins over a clear in the same cycle
	assign nxt_status = (status_ff & ~clr_bits) | events;
	assign nxt_irq = |(nxt_status & nxt_mask);

	////////////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = uart_aux_pkg::READ_ZERO; // [RULE_10]
		if (hit_shadow)
		begin
			rd_mux[uart_aux_pkg::SHADOW_THRESH_MSB:
				uart_aux_pkg::SHADOW_THRESH_LSB] = thresh_ff; // [RULE_01]
		end
		else if (hit_halt)
		begin
			rd_mux[uart_aux_pkg::HALT_BIT] = halt_ff;
		end
		else if (hit_fcr)
		begin
			rd_mux[uart_aux_pkg::FCR_ENABLE_BIT] = fifo_en_ff;
			rd_mux[uart_aux_pkg::FCR_PROG_MODE_BIT] = prog_mode_ff;
			rd_mux[uart_aux_pkg::FCR_THRESH_MSB:
				uart_aux_pkg::FCR_THRESH_LSB] = thresh_ff;
		end
		else if (hit_status)
		begin
			rd_mux[uart_aux_pkg::IRQ_BITS-1:0] = status_ff;
		end
		else if (hit_mask)
		begin
			rd_mux[uart_aux_pkg::IRQ_BITS-1:0] = mask_ff;
		end
		else
		begin
			rd_mux = uart_aux_pkg::READ_ZERO;
		end
	end

	wire logic nxt_ack;
	wire logic [31:0] nxt_rdata;

	// Ack one cycle after the request, dropped the cycle after
	// A request held past ack is answered again every other cycle
	assign nxt_ack = bus_req & ~ack_ff;
	assign nxt_rdata = (nxt_ack & ~WE_I) ? rd_mux : uart_aux_pkg::READ_ZERO;

	////////////////////////////////////////////////////////////////////////
	// Bus registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ack_ff <= BIT_RESET;
			rdata_ff <= uart_aux_pkg::READ_ZERO;
		end
		else
		begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			thresh_ff <= uart_aux_pkg::THRESH_RESET;
			halt_ff <= uart_aux_pkg::HALT_RESET;
			fifo_en_ff <= uart_aux_pkg::FIFO_ENABLE_RESET;
			prog_mode_ff <= uart_aux_pkg::PROG_MODE_RESET;
			mask_ff <= uart_aux_pkg::IRQ_RESET;
		end
		else
		begin
			thresh_ff <= nxt_thresh;
			halt_ff <= nxt_halt;
			fifo_en_ff <= nxt_fifo_en;
			prog_mode_ff <= nxt_prog_mode;
			mask_ff <= nxt_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status and output registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			status_ff <= uart_aux_pkg::IRQ_RESET;
			irq_ff <= BIT_RESET;
			tx_empty_ff <= BIT_RESET;
			tx_halt_ff <= BIT_RESET;
			fifo_reset_ff <= BIT_RESET;
		end
		else
		begin
			status_ff <= nxt_status;
			irq_ff <= nxt_irq;
			tx_empty_ff <= nxt_tx_empty;
			tx_halt_ff <= nxt_tx_halt;
			fifo_reset_ff <= nxt_fifo_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// DMA request registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			block_ff <= DMA_NONE;
			dma_ff <= DMA_NONE;
		end
		else
		begin
			block_ff <= nxt_block;
			dma_ff <= nxt_dma;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign DAT_O = rdata_ff;
	assign ACK_O = ack_ff;
	assign DMA_REQ = dma_ff;
	assign TX_EMPTY_INT = tx_empty_ff;
	assign TX_HALT = tx_halt_ff;
	assign FIFO_ENABLE = fifo_en_ff;
	assign FIFO_RESET = fifo_reset_ff;
	assign IRQ = irq_ff;

endmodule : uart_fifo_dma_aux_control

`default_nettype wire

// ===== sim/uart_aux_sva.sv
// Port checker for the FIFO/DMA aux block
`timescale 1ns/1ps
`default_nettype none
module uart_aux_sva
#(
	parameter int LEVEL_W = 5
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [31:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic [31:0] DAT_O,
	input wire logic ACK_O,
	input wire logic [LEVEL_W-1:0] TX_FIFO_LEVEL,
	input wire uart_aux_pkg::dma_lines_t DMA_REQ_RAW,
	input wire uart_aux_pkg::dma_lines_t DMA_REQ,
	input wire logic TX_EMPTY_INT,
	input wire logic TX_HALT,
	input wire logic FIFO_ENABLE,
	input wire logic FIFO_RESET
);
wire logic wr;
wire logic sack;
wire logic hset;
assign wr = CYC_I && STB_I && WE_I && ACK_O && SEL_I[0] && DAT_I[0];
assign sack = wr && ADR_I == uart_aux_pkg::ADR_DMA_SOFTWARE_ACKNOWLEDGE;
assign hset = wr && ADR_I == uart_aux_pkg::ADR_TRANSMIT_HALT_CONTROL;
default clocking cb @(posedge CLK);
endclocking
default disable iff (RST);
property p_sack_clr;
	sack |=> DMA_REQ == 4'h0;
endproperty
a_sack_clr: assert property (p_sack_clr) else $error("lines kept");
property p_follow;
	DMA_REQ.rx_single |-> $past(DMA_REQ_RAW.rx_single);
endproperty
a_follow: assert property (p_follow) else $error("line w/o raw");
property p_rearm;
	sack ##1 !DMA_REQ_RAW.tx_req ##1 DMA_REQ_RAW.tx_req |=> DMA_REQ.tx_req;
endproperty
a_rearm: assert property (p_rearm) else $error("ack stuck");
property p_halt_set;
	hset && FIFO_ENABLE |-> ##[1:2] TX_HALT;
endproperty
a_halt_set: assert property (p_halt_set) else $error("no halt");
property p_halt_gate;
	!FIFO_ENABLE [*2] |-> !TX_HALT;
endproperty
a_halt_gate: assert property (p_halt_gate) else $error("halt w/o fifo");
property p_thr_cap;
	$past(TX_FIFO_LEVEL) > 8 |-> !TX_EMPTY_INT;
endproperty
a_thr_cap: assert property (p_thr_cap) else $error("empty too high");
property p_plain;
	!$past(RST) && !FIFO_ENABLE && !$past(FIFO_ENABLE)
		|-> TX_EMPTY_INT == ($past(TX_FIFO_LEVEL) == 0);
endproperty
a_plain: assert property (p_plain) else $error("empty mismatch");
property p_fifo_rst;
	$fell(FIFO_ENABLE) |-> ##[0:1] FIFO_RESET;
endproperty
a_fifo_rst: assert property (p_fifo_rst) else $error("no fifo reset");
property p_ack_lat;
	CYC_I && STB_I && !ACK_O |=> ACK_O;
endproperty
a_ack_lat: assert property (p_ack_lat) else $error("ack late");
property p_ack_pulse;
	ACK_O |=> !ACK_O;
endproperty
a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
property p_rd_zero;
	!ACK_O || (!WE_I && ADR_I == uart_aux_pkg::ADR_DMA_SOFTWARE_ACKNOWLEDGE)
		|-> DAT_O == 32'h00000000;
endproperty
a_rd_zero: assert property (p_rd_zero) else $error("data not zero");
c_sack: cover property (sack);
c_fifo_rst: cover property ($fell(FIFO_ENABLE));
c_halt: cover property (hset && FIFO_ENABLE);
endmodule : uart_aux_sva
////////////////////////////////////////////////////////////////////////////
bind uart_fifo_dma_aux_control uart_aux_sva #(.LEVEL_W(LEVEL_W)) u_uart_aux_sva
(
	.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
	.ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
	.ACK_O(ACK_O), .TX_FIFO_LEVEL(TX_FIFO_LEVEL), .DMA_REQ_RAW(DMA_REQ_RAW),
	.DMA_REQ(DMA_REQ), .TX_EMPTY_INT(TX_EMPTY_INT), .TX_HALT(TX_HALT),
	.FIFO_ENABLE(FIFO_ENABLE), .FIFO_RESET(FIFO_RESET)
);
`default_nettype wire

// ===== sim/dma_ctrl_model.sv
// DMA controller model that shuts its channel after a long request
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_model
(
	input wire logic clk,
	input wire logic rst,
	input wire uart_aux_pkg::dma_lines_t req,
	output logic chan_off
);
logic [2:0] busy_ff;
// Four cycles of tx_req in all, counted without clearing, stand for a channel fault
assign chan_off = busy_ff >= 3'h4;
always_ff @(posedge clk)
begin
	if (rst)
		busy_ff <= 3'h0;
	else if (req.tx_req && !chan_off)
		busy_ff <= busy_ff + 3'h1;
end
endmodule : dma_ctrl_model
`default_nettype wire

// ===== sim/uart_fifo_dma_aux_control_test.sv
// Register-level test of the FIFO/DMA aux block
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_dma_aux_control_test;
localparam int DEPTH = 16;
localparam logic [31:0] SH = uart_aux_pkg::ADR_TX_EMPTY_THRESHOLD_SHADOW;
localparam logic [31:0] HT = uart_aux_pkg::ADR_TRANSMIT_HALT_CONTROL;
localparam logic [31:0] DA = uart_aux_pkg::ADR_DMA_SOFTWARE_ACKNOWLEDGE;
localparam logic [31:0] FC = uart_aux_pkg::ADR_FIFO_CONTROL_REGISTER;
localparam logic [31:0] ST = uart_aux_pkg::ADR_IRQ_STATUS;
localparam logic [31:0] MK = uart_aux_pkg::ADR_IRQ_MASK;
logic clk = 1'b0;
logic rst = 1'b1;
logic cyc = 1'b0;
logic stb = 1'b0;
logic we = 1'b0;
logic [31:0] adr = 32'h0;
logic [31:0] dat = 32'h0;
logic [3:0] sel = 4'hF;
logic [31:0] rd;
logic [4:0] lvl = 5'h0;
uart_aux_pkg::dma_lines_t raw = 4'h0;
uart_aux_pkg::dma_lines_t req;
wire logic [31:0] dat_o;
wire logic ack, tx_empty, halt, fen, irq, chan_off;
int errors = 0;
int tests_run = 0;
int thr [4] = '{0, 2, DEPTH / 4, DEPTH / 2};
always #12.5 clk = ~clk;
uart_fifo_dma_aux_control #(.FIFO_DEPTH(DEPTH)) u_uart_fifo_dma_aux_control
(
	.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
	.SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
	.TX_FIFO_LEVEL(lvl), .DMA_REQ_RAW(raw), .DMA_REQ(req),
	.TX_EMPTY_INT(tx_empty), .TX_HALT(halt), .FIFO_ENABLE(fen),
	.FIFO_RESET(), .IRQ(irq)
);
dma_ctrl_model u_dma_ctrl_model
(
	.clk(clk), .rst(rst), .req(req), .chan_off(chan_off)
);
////////////////////////////////////////////////////////////////////////////
task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
	int n;
	@(posedge clk);
	{cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
	n = 0;
	do @(posedge clk); while (!ack && ++n < 50);
	if (!ack)
	begin
		errors++;
		$display("CHECK FAILED t=%0t no ack", $time);
	end
	rd = dat_o;
	{cyc, stb} <= 2'h0;
endtask : wb
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	tests_run++;
	if (g !== e)
	begin
		errors++;
		$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
	end
endtask : chk
task automatic rdc(input logic [31:0] a, input logic [31:0] e);
	wb(1'b0, a, 32'h0);
	chk(rd, e);
endtask : rdc
task automatic give_verdict;
	$display("%0d checks, %0d errors", tests_run, errors);
	if (errors == 0 && tests_run > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask : give_verdict
////////////////////////////////////////////////////////////////////////////
// The whole sequence needs under 150 cycles
initial
begin
	#100000;
	errors++;
	give_verdict();
end
initial
begin
	repeat (10) @(posedge clk);
	rst <= 1'b0;
	rdc(SH, 32'h0);
	rdc(HT, 32'h0);
	rdc(DA, 32'h0);
	rdc(32'h500010AC, 32'h0);
	$display("reset test done");
	wb(1'b1, FC, 32'h09);
	wb(1'b1, SH, 32'hFF);
	rdc(SH, 32'h3);
	rdc(FC, 32'h39);
	sel <= 4'hE;
	wb(1'b1, SH, 32'h0);
	sel <= 4'hF;
	rdc(SH, 32'h3);
	$display("shadow test done");
	for (int i = 0; i < 4; i++)
	begin
		wb(1'b1, SH, 32'(i));
		lvl <= 5'(thr[i]);
		repeat (3) @(posedge clk);
		chk(32'(tx_empty), 32'h1);
		lvl <= 5'(thr[i] + 1);
		repeat (3) @(posedge clk);
		chk(32'(tx_empty), 32'h0);
	end
	$display("threshold test done");
	wb(1'b1, HT, 32'h1);
	repeat (2) @(posedge clk);
	chk(32'(halt), 32'h1);
	wb(1'b1, FC, 32'h0);
	repeat (2) @(posedge clk);
	chk(32'(fen), 32'h0);
	chk(32'(halt), 32'h0);
	rdc(HT, 32'h1);
	$display("halt test done");
	rdc(ST, 32'h5);
	wb(1'b1, ST, 32'h7);
	wb(1'b1, MK, 32'h0);
	raw <= 4'hF;
	repeat (20) if (!chan_off) @(posedge clk);
	chk(32'(chan_off), 32'h1);
	wb(1'b1, DA, 32'h1);
	repeat (2) @(posedge clk);
	chk(32'(req), 32'h0);
	rdc(DA, 32'h0);
	rdc(ST, 32'h2);
	chk(32'(irq), 32'h0);
	wb(1'b1, MK, 32'h2);
	repeat (2) @(posedge clk);
	chk(32'(irq), 32'h1);
	wb(1'b1, ST, 32'h2);
	repeat (2) @(posedge clk);
	chk(32'(irq), 32'h0);
	raw <= 4'h0;
	repeat (2) @(posedge clk);
	raw <= 4'hF;
	repeat (3) @(posedge clk);
	chk(32'(req), 32'hF);
	wb(1'b1, DA, 32'h1);
	raw <= 4'h0;
	@(posedge clk);
	chk(32'(req), 32'h0);
	raw <= 4'hF;
	repeat (3) @(posedge clk);
	chk(32'(req), 32'hF);
	$display("dma test done");
	give_verdict();
end
endmodule : uart_fifo_dma_aux_control_test
`default_nettype wire
